// *** hw/usart_sync_pkg.sv ***
// constants for the synchronous slave serial port
package usart_sync_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  localparam int WORD_W = 9;
  localparam int CNT_W = 4;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_INTERRUPT_CONTROL = 8'h0b;
  localparam logic [7:0] IDX_PERIPHERAL_IRQ_FLAGS = 8'h0c;
  localparam logic [7:0] IDX_RECEIVE_STATUS_CONTROL = 8'h18;
  localparam logic [7:0] IDX_TRANSMIT_HOLDING = 8'h19;
  localparam logic [7:0] IDX_RECEIVE_FIFO_HEAD = 8'h1a;
  localparam logic [7:0] IDX_PERIPHERAL_IRQ_ENABLES = 8'h8c;
  localparam logic [7:0] IDX_TRANSMIT_STATUS_CONTROL = 8'h98;
  localparam logic [7:0] IDX_BAUD_DIVISOR = 8'h99;

  // interrupt_control fields
  localparam int BIT_GLOBAL_IRQ_EN = 7;
  localparam int BIT_PERIPH_IRQ_EN = 6;
  // peripheral flag and enable fields
  localparam int BIT_RX_AVAIL = 5;
  localparam int BIT_TX_READY = 4;
  // receive_status_control fields
  localparam int BIT_PORT_EN = 7;
  localparam int BIT_RX_NINE = 6;
  localparam int BIT_RX_SINGLE = 5;
  localparam int BIT_RX_CONT = 4;
  localparam int BIT_FRAMING = 2;
  localparam int BIT_OVERRUN = 1;
  localparam int BIT_RX_NINTH = 0;
  // transmit_status_control fields
  localparam int BIT_CLK_SRC = 7;
  localparam int BIT_TX_NINE = 6;
  localparam int BIT_TX_EN = 5;
  localparam int BIT_SYNC_MODE = 4;
  localparam int BIT_HIGH_BAUD = 2;
  localparam int BIT_SHIFT_EMPTY = 1;
  localparam int BIT_TX_NINTH = 0;

  // software-writable bits and reset values of stored bits
  localparam logic [7:0] INTCTL_WMASK = 8'hc0;
  localparam logic [7:0] RECEIVE_STATUS_CONTROL_WMASK = 8'hf0;
  localparam logic [7:0] TRANSMIT_STATUS_CONTROL_WMASK = 8'hf5;
  localparam logic [7:0] REG_RST = 8'h00;

  localparam logic [CNT_W-1:0] BITS_EIGHT = 4'h8;
  localparam logic [CNT_W-1:0] BITS_NINE = 4'h9;
  localparam int FIFO_DEPTH_DEF = 2;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_SHIFT = 2'b01
  } tx_state_t;
endpackage : usart_sync_pkg

// *** hw/usart_sync_slave.sv ***
// synchronous slave serial port with avalon-mm register slave
// Behaviour
// - first of two queued words starts shifting immediately
// - second word waits; transmit-ready stays clear
// - after first word, load second, set ready
// - ready with enables wakes core, vectors if global
// - slave transfers behave like master transfers
// - writing holding register starts a transfer
// - single-receive enable ignored in slave mode
// - continuous receive pushes finished word into fifo
// - receive completion with enables wakes the core
// - completion sets receive-available and raises interrupt
// - clearing continuous receive clears error flag
// - external party supplies clock; slave when cleared
// - receive data sampled on falling shift clock
// - two-deep fifo; full third word sets overrun
// - ninth bit travels with its byte in fifo
`timescale 1ns/10ps
module usart_sync_slave
  import usart_sync_pkg::*;
#(
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [DATA_W-1:0] writedata,
  output logic [DATA_W-1:0] readdata,
  output logic waitrequest,
  input wire logic ck_in,
  input wire logic dt_in,
  output logic dt_out,
  output logic dt_oe,
  output logic irq,
  output logic wake
);
  // fifo depth must be a power of two so pointers wrap by themselves
  localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
  localparam logic [PW:0] FIFO_FULL = (PW+1)'(FIFO_DEPTH);

  // pin synchronisers; first stage feeds only the second
  logic ck_s1_r, ck_s2_r, ck_s3_r;
  logic dt_s1_r, dt_s2_r;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ck_s1_r <= 1'b0;
      ck_s2_r <= 1'b0;
      ck_s3_r <= 1'b0;
      dt_s1_r <= 1'b0;
      dt_s2_r <= 1'b0;
    end else begin
      ck_s1_r <= ck_in;
      ck_s2_r <= ck_s1_r;
      ck_s3_r <= ck_s2_r;
      dt_s1_r <= dt_in;
      dt_s2_r <= dt_s1_r;
    end
  end

  logic ck_rise, ck_fall;
  assign ck_rise = ck_s2_r & ~ck_s3_r;
  assign ck_fall = ~ck_s2_r & ck_s3_r;

  // state and its next values
  logic [7:0] intctl_r, intctl_nxt;
  logic [7:0] pie_r, pie_nxt;
  logic [7:0] receive_status_control_r, receive_status_control_nxt;
  logic [7:0] transmit_status_control_r, transmit_status_control_nxt;
  logic [7:0] brg_r, brg_nxt;
  logic [WORD_W-1:0] hold_r, hold_nxt;
  logic hold_full_r, hold_full_nxt;
  logic [WORD_W-1:0] tsr_r, tsr_nxt;
  tx_state_t tx_state_r, tx_state_nxt;
  logic [CNT_W-1:0] tx_cnt_r, tx_cnt_nxt;
  logic tx_pend_r, tx_pend_nxt;
  logic [WORD_W-1:0] rsr_r, rsr_nxt;
  logic [CNT_W-1:0] rx_cnt_r, rx_cnt_nxt;
  logic [WORD_W-1:0] fifo_r [FIFO_DEPTH];
  logic [WORD_W-1:0] fifo_nxt [FIFO_DEPTH];
  logic [PW:0] fifo_cnt_r, fifo_cnt_nxt;
  logic [PW-1:0] rd_ptr_r, rd_ptr_nxt;
  logic overrun_flag_r, overrun_flag_nxt;
  logic transmit_ready_flag_r, transmit_ready_flag_nxt;
  logic irq_r, irq_nxt;
  logic wake_r, wake_nxt;
  logic wait_r, wait_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic dt_out_r, dt_out_nxt;
  logic dt_oe_r, dt_oe_nxt;

  logic slave_on, rx_on, tx_on, receive_available_flag;
  logic acc, wr_acc, rd_acc;
  logic [CNT_W-1:0] tx_last, rx_last;
  logic [WORD_W-1:0] rx_word;
  logic [PW-1:0] wr_idx;
  logic push, pop;
  logic [7:0] pir_v, receive_status_control_v, transmit_status_control_v;

  // port only shifts on the external clock in sync slave setup
  assign slave_on = receive_status_control_r[BIT_PORT_EN] & transmit_status_control_r[BIT_SYNC_MODE]
                    & ~transmit_status_control_r[BIT_CLK_SRC];
  // single-receive bit deliberately not looked at here
  assign rx_on = slave_on & receive_status_control_r[BIT_RX_CONT];
  // half duplex: receive takes the data pin when both enabled
  assign tx_on = slave_on & transmit_status_control_r[BIT_TX_EN] & ~receive_status_control_r[BIT_RX_CONT];
  assign receive_available_flag = (fifo_cnt_r != '0);

  assign acc = (read | write) & ~wait_r;
  assign wr_acc = acc & write;
  assign rd_acc = acc & read;
  assign tx_last = (transmit_status_control_r[BIT_TX_NINE] ? BITS_NINE : BITS_EIGHT) - 4'h1;
  assign rx_last = (receive_status_control_r[BIT_RX_NINE] ? BITS_NINE : BITS_EIGHT) - 4'h1;
  assign wr_idx = PW'(rd_ptr_r + fifo_cnt_r);

  assign pir_v = {2'b00, receive_available_flag, transmit_ready_flag_r, 4'h0};
  assign receive_status_control_v = {receive_status_control_r[7:4], 1'b0, 1'b0, overrun_flag_r,
                    fifo_r[rd_ptr_r][WORD_W-1]};
  assign transmit_status_control_v = {transmit_status_control_r[7:2], (tx_state_r == TX_IDLE),
                    transmit_status_control_r[BIT_TX_NINTH]};

  always_comb begin
    intctl_nxt = intctl_r;
    pie_nxt = pie_r;
    receive_status_control_nxt = receive_status_control_r;
    transmit_status_control_nxt = transmit_status_control_r;
    brg_nxt = brg_r;
    hold_nxt = hold_r;
    hold_full_nxt = hold_full_r;
    tsr_nxt = tsr_r;
    tx_state_nxt = tx_state_r;
    tx_cnt_nxt = tx_cnt_r;
    tx_pend_nxt = tx_pend_r;
    rsr_nxt = rsr_r;
    rx_cnt_nxt = rx_cnt_r;
    fifo_nxt = fifo_r;
    fifo_cnt_nxt = fifo_cnt_r;
    rd_ptr_nxt = rd_ptr_r;
    overrun_flag_nxt = overrun_flag_r;
    rx_word = rsr_r;
    push = 1'b0;
    pop = 1'b0;
    rdata_nxt = rdata_r;
    // one wait cycle, then the access completes with waitrequest low
    wait_nxt = ~((read | write) & wait_r);

    if ((read | write) & wait_r) begin
      rdata_nxt = '0;
      unique case (address)
        IDX_INTERRUPT_CONTROL: rdata_nxt[7:0] = intctl_r;
        IDX_PERIPHERAL_IRQ_FLAGS: rdata_nxt[7:0] = pir_v;
        IDX_RECEIVE_STATUS_CONTROL: rdata_nxt[7:0] = receive_status_control_v;
        IDX_RECEIVE_FIFO_HEAD: rdata_nxt[7:0] = fifo_r[rd_ptr_r][7:0];
        IDX_PERIPHERAL_IRQ_ENABLES: rdata_nxt[7:0] = pie_r;
        IDX_TRANSMIT_STATUS_CONTROL: rdata_nxt[7:0] = transmit_status_control_v;
        IDX_BAUD_DIVISOR: rdata_nxt[7:0] = brg_r;
        default: rdata_nxt = '0;
      endcase
    end

    // transmit shifter; loading happens before a same-cycle write
    unique case (tx_state_r)
      TX_IDLE: begin
        if (tx_on & hold_full_r) begin
          tsr_nxt = hold_r;
          hold_full_nxt = 1'b0;
          tx_cnt_nxt = '0;
          tx_pend_nxt = 1'b0;
          tx_state_nxt = TX_SHIFT;
        end
      end
      TX_SHIFT: begin
        if (!tx_on) begin
          tx_state_nxt = TX_IDLE;
        end else if (ck_fall) begin
          if (tx_cnt_r == tx_last) begin
            tx_state_nxt = TX_IDLE;
          end else begin
            tx_cnt_nxt = tx_cnt_r + 4'h1;
            tx_pend_nxt = 1'b1;
          end
        end else if (ck_rise & tx_pend_r) begin
          // next bit goes out on the rising edge, held over the fall
          tsr_nxt = {1'b0, tsr_r[WORD_W-1:1]};
          tx_pend_nxt = 1'b0;
        end
      end
    endcase

    // receive shifter, lsb first, sampled on the falling edge
    if (!receive_status_control_r[BIT_RX_CONT]) begin
      rx_cnt_nxt = '0;
      overrun_flag_nxt = 1'b0;
    end else if (rx_on & ck_fall) begin
      if (receive_status_control_r[BIT_RX_NINE]) begin
        rx_word = {dt_s2_r, rsr_r[WORD_W-1:1]};
      end else begin
        rx_word = {1'b0, dt_s2_r, rsr_r[7:1]};
      end
      rsr_nxt = rx_word;
      if (rx_cnt_r == rx_last) begin
        rx_cnt_nxt = '0;
        // a pop in this same cycle does not rescue a full fifo
        if (overrun_flag_r) begin
          push = 1'b0;
        end else if (fifo_cnt_r == FIFO_FULL) begin
          overrun_flag_nxt = 1'b1;
        end else begin
          push = 1'b1;
        end
      end else begin
        rx_cnt_nxt = rx_cnt_r + 4'h1;
      end
    end

    if (push) begin
      fifo_nxt[wr_idx] = rx_word;
    end

    if (wr_acc) begin
      unique case (address)
        IDX_INTERRUPT_CONTROL: intctl_nxt = writedata[7:0] & INTCTL_WMASK;
        IDX_RECEIVE_STATUS_CONTROL: receive_status_control_nxt = writedata[7:0] & RECEIVE_STATUS_CONTROL_WMASK;
        IDX_TRANSMIT_HOLDING: begin
          // ninth bit is taken from the control register at this write
          hold_nxt = {transmit_status_control_r[BIT_TX_NINTH], writedata[7:0]};
          hold_full_nxt = 1'b1;
        end
        IDX_PERIPHERAL_IRQ_ENABLES: pie_nxt = writedata[7:0];
        IDX_TRANSMIT_STATUS_CONTROL: transmit_status_control_nxt = writedata[7:0] & TRANSMIT_STATUS_CONTROL_WMASK;
        IDX_BAUD_DIVISOR: brg_nxt = writedata[7:0];
        default: brg_nxt = brg_r;
      endcase
    end

    if (rd_acc & (address == IDX_RECEIVE_FIFO_HEAD) & receive_available_flag) begin
      pop = 1'b1;
      rd_ptr_nxt = rd_ptr_r + 1'b1;
    end
    fifo_cnt_nxt = fifo_cnt_r + (PW+1)'(push) - (PW+1)'(pop);

    // ready only while the holding register is free
    transmit_ready_flag_nxt = transmit_status_control_nxt[BIT_TX_EN] & ~hold_full_nxt;
    dt_out_nxt = tsr_nxt[0];
    dt_oe_nxt = tx_on & (tx_state_nxt == TX_SHIFT);
  end

  // events gated by their enables and the peripheral enable
  logic ev_pending;
  always_comb begin
    ev_pending = intctl_r[BIT_PERIPH_IRQ_EN] &
                 ((transmit_ready_flag_r & pie_r[BIT_TX_READY]) |
                  (receive_available_flag & pie_r[BIT_RX_AVAIL]));
    wake_nxt = ev_pending;
    // the core branches to its vector only with the global enable
    irq_nxt = ev_pending & intctl_r[BIT_GLOBAL_IRQ_EN];
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      intctl_r <= REG_RST;
      pie_r <= REG_RST;
      receive_status_control_r <= REG_RST;
      transmit_status_control_r <= REG_RST;
      brg_r <= REG_RST;
      hold_r <= '0;
      hold_full_r <= 1'b0;
      tsr_r <= '0;
      tx_state_r <= TX_IDLE;
      tx_cnt_r <= '0;
      tx_pend_r <= 1'b0;
      rsr_r <= '0;
      rx_cnt_r <= '0;
      fifo_cnt_r <= '0;
      rd_ptr_r <= '0;
      overrun_flag_r <= 1'b0;
      transmit_ready_flag_r <= 1'b0;
      irq_r <= 1'b0;
      wake_r <= 1'b0;
      wait_r <= 1'b1;
      rdata_r <= '0;
      dt_out_r <= 1'b0;
      dt_oe_r <= 1'b0;
    end else begin
      intctl_r <= intctl_nxt;
      pie_r <= pie_nxt;
      receive_status_control_r <= receive_status_control_nxt;
      transmit_status_control_r <= transmit_status_control_nxt;
      brg_r <= brg_nxt;
      hold_r <= hold_nxt;
      hold_full_r <= hold_full_nxt;
      tsr_r <= tsr_nxt;
      tx_state_r <= tx_state_nxt;
      tx_cnt_r <= tx_cnt_nxt;
      tx_pend_r <= tx_pend_nxt;
      rsr_r <= rsr_nxt;
      rx_cnt_r <= rx_cnt_nxt;
      fifo_cnt_r <= fifo_cnt_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      overrun_flag_r <= overrun_flag_nxt;
      transmit_ready_flag_r <= transmit_ready_flag_nxt;
      irq_r <= irq_nxt;
      wake_r <= wake_nxt;
      wait_r <= wait_nxt;
      rdata_r <= rdata_nxt;
      dt_out_r <= dt_out_nxt;
      dt_oe_r <= dt_oe_nxt;
    end
  end

  // fifo storage, one register per entry
  genvar gi;
  generate
    for (gi = 0; gi < FIFO_DEPTH; gi++) begin : g_fifo
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          fifo_r[gi] <= '0;
        end else begin
          fifo_r[gi] <= fifo_nxt[gi];
        end
      end
    end
  endgenerate

  assign readdata = rdata_r;
  assign waitrequest = wait_r;
  assign dt_out = dt_out_r;
  assign dt_oe = dt_oe_r;
  assign irq = irq_r;
  assign wake = wake_r;
endmodule : usart_sync_slave

// *** dv/usart_sync_slave_sva.sv ***
// assertion checker for the synchronous slave serial port
`timescale 1ns/10ps
module usart_sync_slave_sva
  import usart_sync_pkg::*;
#(
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
  input logic mclk,
  input logic rst,
  input logic [ADDR_W-1:0] address,
  input logic read,
  input logic write,
  input logic [DATA_W-1:0] writedata,
  input logic [DATA_W-1:0] readdata,
  input logic waitrequest,
  input logic ck_in,
  input logic dt_in,
  input logic dt_out,
  input logic dt_oe,
  input logic irq,
  input logic wake
);
  // shadow of control writes: interrupt, receive, transmit
  logic [23:0] sh_r;
  logic [23:0] sh_nxt;
  logic rd_ok;
  logic tx_go;
  assign rd_ok = read && !waitrequest;
  assign tx_go = sh_r[15] && !sh_r[12] && sh_r[5] && sh_r[4] && !sh_r[7];
  always_comb begin
    sh_nxt = sh_r;
    if (write && !waitrequest) begin
      case (address)
        IDX_INTERRUPT_CONTROL: sh_nxt[23:16] = writedata[7:0];
        IDX_RECEIVE_STATUS_CONTROL: sh_nxt[15:8] = writedata[7:0];
        IDX_TRANSMIT_STATUS_CONTROL: sh_nxt[7:0] = writedata[7:0];
        default: sh_nxt = sh_r;
      endcase
    end
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) sh_r <= '0;
    else sh_r <= sh_nxt;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_grant;
    !waitrequest ##1 waitrequest;
  endsequence
  wait_once_a:
    assert property ((read || write) && waitrequest |=> s_grant)
    else $error("bus grant not exactly one cycle");
  irq_wake_a:
    assert property (irq |-> wake)
    else $error("irq without wake");
  glob_gate_a:
    assert property ((!sh_r[23])[*3] |-> !irq)
    else $error("irq with global enable clear");
  periph_gate_a:
    assert property ((!sh_r[22])[*3] |-> !wake && !irq)
    else $error("wake with peripheral enable clear");
  flags_clean_a:
    assert property (rd_ok && address == IDX_PERIPHERAL_IRQ_FLAGS
      |-> (readdata[7:0] & 8'hcf) == 8'h00)
    else $error("unused flag bits set");
  ovr_clear_a:
    assert property (rd_ok && address == IDX_RECEIVE_STATUS_CONTROL
      && !sh_r[12] |-> !readdata[1])
    else $error("overrun stands with receive off");
  tx_start_a:
    assert property (write && !waitrequest && !dt_oe && tx_go
      && address == IDX_TRANSMIT_HOLDING |-> ##[1:4] dt_oe)
    else $error("holding write started no transfer");
  tx_refuse_a:
    assert property ((sh_r[7] || sh_r[12] || !sh_r[5] || !sh_r[15])
      && !dt_oe |=> !dt_oe)
    else $error("shifting while transmit not allowed");
  bit_hold_a:
    assert property ($fell(ck_in) && dt_oe |-> ##1 $stable(dt_out)[*2])
    else $error("data bit moved at clock fall");
endmodule : usart_sync_slave_sva
bind usart_sync_slave usart_sync_slave_sva #(.FIFO_DEPTH(FIFO_DEPTH)) u_sva (
  .mclk, .rst, .address, .read, .write, .writedata, .readdata,
  .waitrequest, .ck_in, .dt_in, .dt_out, .dt_oe, .irq, .wake);

// *** dv/sync_master_model.sv ***
// external master model: drives shift clock and data line
`timescale 1ns/10ps
module sync_master_model (
  input logic dt_out,
  input logic dt_oe,
  output logic ck,
  output logic dt_line
);
  logic m_oe = 1'b0;
  logic m_dt = 1'b0;
  logic idle_v = 1'b0;
  // no pull on the line: released level flips so stale bits never match
  assign dt_line = dt_oe ? dt_out : (m_oe ? m_dt : idle_v);
  initial ck = 1'b0; // idle low outside frames
  task automatic xfer(input logic [8:0] tx, input int n, input logic drv,
                      output logic [8:0] rx);
    rx = '0;
    // step off the core clock edge that the caller returned on
    #1 m_oe = drv;
    for (int i = 0; i < n; i++) begin
      #83 ck = 1'b1; // odd offset keeps phase off the core clock
      m_dt = tx[i]; // lsb first, steady across the fall
      #77 rx[i] = dt_line;
      ck = 1'b0;
    end
    #80 m_oe = 1'b0;
    idle_v = ~m_dt;
  endtask : xfer
endmodule : sync_master_model

// *** dv/testbench.sv ***
// self-checking testbench for the synchronous slave serial port
`timescale 1ns/10ps
module testbench;
  import usart_sync_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] address = '0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [DATA_W-1:0] writedata = '0;
  logic [DATA_W-1:0] readdata;
  logic waitrequest, ck_in, dt_in, dt_out, dt_oe, irq, wake;
  int err_total = 0;
  int checks = 0;
  logic [15:0] expq[$];
  logic [15:0] e;
  logic [31:0] seed = 32'd84992;
  logic [8:0] w[0:3];
  logic [8:0] got;
  usart_sync_slave u_usart_sync_slave (.mclk, .rst, .address, .read,
    .write, .writedata, .readdata, .waitrequest, .ck_in, .dt_in, .dt_out,
    .dt_oe, .irq, .wake);
  sync_master_model m_master (.dt_out, .dt_oe, .ck(ck_in), .dt_line(dt_in));
  initial forever #4 mclk = ~mclk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic finish_test;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test
  task automatic tmo;
    err_total++;
    finish_test();
  endtask : tmo
  task automatic bus(input logic rd, input logic [7:0] a,
                     input logic [7:0] d, input logic [7:0] m,
                     input logic [7:0] x);
    int n;
    @(posedge mclk);
    if (rd) expq.push_back({m, x});
    read <= rd;
    write <= !rd;
    address <= a;
    writedata <= {24'h0, d};
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    if (n >= 20) tmo();
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b0, a, d, 8'h00, 8'h00);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] m,
                    input logic [7:0] x);
    bus(1'b1, a, 8'h00, m, x);
  endtask : rd
  task automatic wait_sig(input logic want_irq);
    int n;
    n = 0;
    while ((want_irq ? irq : dt_oe) !== 1'b1 && n < 60) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 60) tmo();
  endtask : wait_sig
  // read results are paired with the oldest note in order of issue
  always @(posedge mclk) begin
    if (read && waitrequest === 1'b0) begin
      e = expq.pop_front();
      chk(readdata[8:0] & {1'b1, e[15:8]}, {1'b0, e[7:0]});
    end
  end
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      repeat (9) seed = lfsr(seed);
      w[i] = seed[8:0];
    end
    rd(IDX_TRANSMIT_STATUS_CONTROL, 8'hff, 8'h02);
    rd(IDX_RECEIVE_STATUS_CONTROL, 8'hff, 8'h00);
    rd(IDX_PERIPHERAL_IRQ_FLAGS, 8'hff, 8'h00);
    wr(8'h00, 8'h5a);
    rd(8'h00, 8'hff, 8'h00);
    wr(IDX_BAUD_DIVISOR, seed[15:8]);
    rd(IDX_BAUD_DIVISOR, 8'hff, seed[15:8]);
    wr(IDX_RECEIVE_STATUS_CONTROL, 8'h80);
    wr(IDX_PERIPHERAL_IRQ_ENABLES, 8'h10);
    rd(IDX_PERIPHERAL_IRQ_ENABLES, 8'hff, 8'h10);
    wr(IDX_INTERRUPT_CONTROL, 8'hc0);
    for (int i = 0; i < 2; i++) begin
      wr(IDX_TRANSMIT_STATUS_CONTROL, 8'h70 | {7'h0, w[i][8]});
      wr(IDX_TRANSMIT_HOLDING, w[i][7:0]);
    end
    rd(IDX_PERIPHERAL_IRQ_FLAGS, 8'h10, 8'h00);
    chk({8'h0, irq}, 9'h000);
    for (int i = 0; i < 2; i++) begin
      wait_sig(1'b0);
      m_master.xfer(9'h000, 9, 1'b0, got);
      chk(got, w[i]);
      if (i == 0) wait_sig(1'b1);
    end
    rd(IDX_PERIPHERAL_IRQ_FLAGS, 8'h10, 8'h10);
    rd(IDX_TRANSMIT_STATUS_CONTROL, 8'h02, 8'h02);
    wr(IDX_INTERRUPT_CONTROL, 8'h40);
    rd(IDX_INTERRUPT_CONTROL, 8'hff, 8'h40);
    chk({7'h0, irq, wake}, 9'h001);
    wr(IDX_TRANSMIT_STATUS_CONTROL, 8'h10);
    wr(IDX_PERIPHERAL_IRQ_ENABLES, 8'h20);
    wr(IDX_INTERRUPT_CONTROL, 8'hc0);
    wr(IDX_RECEIVE_STATUS_CONTROL, 8'hf0);
    // parked in the holding register: transmit is off while receiving
    wr(IDX_TRANSMIT_HOLDING, seed[23:16]);
    for (int i = 0; i < 3; i++) begin
      m_master.xfer(w[i + 1], 9, 1'b1, got);
      if (i == 0) wait_sig(1'b1);
    end
    rd(IDX_RECEIVE_STATUS_CONTROL, 8'h07, {7'h1, w[1][8]});
    rd(IDX_RECEIVE_FIFO_HEAD, 8'hff, w[1][7:0]);
    rd(IDX_RECEIVE_STATUS_CONTROL, 8'h01, {7'h0, w[2][8]});
    rd(IDX_RECEIVE_FIFO_HEAD, 8'hff, w[2][7:0]);
    rd(IDX_PERIPHERAL_IRQ_FLAGS, 8'h20, 8'h00);
    wr(IDX_RECEIVE_STATUS_CONTROL, 8'he0);
    rd(IDX_RECEIVE_STATUS_CONTROL, 8'h02, 8'h00);
    // single-receive alone must not start anything in slave mode
    m_master.xfer(w[0], 9, 1'b1, got);
    rd(IDX_PERIPHERAL_IRQ_FLAGS, 8'h20, 8'h00);
    // eight-bit frame this time: ninth status bit reads clear
    wr(IDX_RECEIVE_STATUS_CONTROL, 8'h90);
    m_master.xfer(w[0], 8, 1'b1, got);
    rd(IDX_RECEIVE_STATUS_CONTROL, 8'h03, 8'h00);
    rd(IDX_RECEIVE_FIFO_HEAD, 8'hff, w[0][7:0]);
    // internal clock source selected: parked word must not move
    wr(IDX_RECEIVE_STATUS_CONTROL, 8'h80);
    wr(IDX_TRANSMIT_STATUS_CONTROL, 8'hb0);
    rd(IDX_TRANSMIT_STATUS_CONTROL, 8'h02, 8'h02);
    chk({8'h0, dt_oe}, 9'h000);
    wr(IDX_TRANSMIT_STATUS_CONTROL, 8'h30);
    wait_sig(1'b0);
    m_master.xfer(9'h000, 8, 1'b0, got);
    chk(got, {1'b0, seed[23:16]});
    finish_test();
  end
endmodule : testbench
